// file: rtl/spat_translator.v
// Segment and page address translator with AXI4-Lite register slave
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "spat_regs.vh"
module spat_translator (
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Translation request
  input  wire        req_valid,
  output reg         req_ready,
  input  wire        req_seg_load,
  input  wire [15:0] req_selector,
  input  wire [31:0] req_offset,
  input  wire        req_off32,
  input  wire        req_wide,
  input  wire        req_sensitive,
  input  wire        req_event,
  // Translation answer
  output reg         rsp_valid,
  output reg  [31:0] rsp_addr,
  output reg         rsp_fault,
  output reg  [1:0]  rsp_cause,
  // Table memory read port
  output reg         mem_req,
  output reg  [31:0] mem_addr,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  output reg         irq
);

  // Sequencer states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_DLO  = 3'h1;
  localparam [2:0] ST_DHI  = 3'h2;
  localparam [2:0] ST_DIR  = 3'h3;
  localparam [2:0] ST_TBL  = 3'h4;

  // Byte-lane merge, used by every writable register except the write-one-to-clear status word
  function [31:0] spat_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      spat_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          spat_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // Register file
  reg  [`SPAT_CTRL_W-1:0] ctrl_ff;     // Protect, paging, legacy flag
  reg  [`SPAT_EV_W-1:0]   status_ff;   // Sticky events
  reg  [`SPAT_EV_W-1:0]   mask_ff;     // Interrupt enables
  reg  [31:0]             fault_address_reg_ff;
  reg  [31:0]             directory_base_reg_ff;
  reg  [31:0]             gtbase_ff;   // Global table base
  reg  [31:0]             ltbase_ff;   // Local table base
  reg  [31:0]             segbase_ff;  // Loaded protected segment base
  reg  [`SPAT_CTRL_W-1:0] image_ff;    // Flags image saved on exception

  // Write channel holding
  reg                     aw_have_ff;
  reg                     w_have_ff;
  reg  [7:0]              awaddr_ff;
  reg  [31:0]             wdata_ff;
  reg  [3:0]              wstrb_ff;

  // Sequencer state
  reg  [2:0]              state_ff;
  reg  [31:0]             lin_ff;      // Linear address in flight
  reg  [15:0]             sel_ff;      // Selector being loaded
  reg  [31:0]             dlo_ff;      // Low descriptor word

  // Combinational helpers
  reg  [31:0]             nxt_lin;
  wire                    prot_on   = ctrl_ff[`SPAT_CTRL_PROT];
  wire                    page_on   = ctrl_ff[`SPAT_CTRL_PAGE];
  wire                    legacy_on = ctrl_ff[`SPAT_CTRL_LEGACY] & prot_on;
  wire                    wr_fire   = aw_have_ff & w_have_ff & ~s_axi_bvalid;
  wire                    aw_fire   = s_axi_awvalid & s_axi_awready;
  wire                    w_fire    = s_axi_wvalid & s_axi_wready;
  wire                    ar_fire   = s_axi_arvalid & s_axi_arready;
  wire                    req_fire  = req_valid & req_ready;
  wire [19:0]             real_sum;
  wire                    wr_map;
  reg  [`SPAT_EV_W-1:0]   ev_set;
  reg                     nxt_aw_have;
  reg                     nxt_w_have;
  // Merged write values, cut on purpose to the register widths where they land
  wire [31:0]             ctrl_wr   = spat_merge({29'h0, ctrl_ff}, wdata_ff, wstrb_ff);
  wire [31:0]             mask_wr   = spat_merge({28'h0, mask_ff}, wdata_ff, wstrb_ff);

  // Real and legacy address: segment shifted by four plus 16-bit offset, wrapping at 1MB
  assign real_sum = {req_selector, 4'h0} + {4'h0, req_offset[15:0]};

  // Offset decode for writes
  assign wr_map = (awaddr_ff == `SPAT_OFF_CTRL)    | (awaddr_ff == `SPAT_OFF_STATUS) |
                  (awaddr_ff == `SPAT_OFF_MASK)    | (awaddr_ff == `SPAT_OFF_FAULT)  |
                  (awaddr_ff == `SPAT_OFF_DIRBASE) | (awaddr_ff == `SPAT_OFF_GTBASE) |
                  (awaddr_ff == `SPAT_OFF_LTBASE);

  // Linear address of an accepted translation request
  always @* begin
    if (legacy_on | ~prot_on) begin
      nxt_lin = {12'h000, real_sum};
    end else if (req_off32) begin
      nxt_lin = segbase_ff + req_offset;
    end else begin
      nxt_lin = segbase_ff + {16'h0000, req_offset[15:0]};
    end
  end

  // Events raised this cycle
  always @* begin
    ev_set = `SPAT_EV_RST;
    if (req_valid & req_event) begin
      ev_set[`SPAT_EV_EXT] = 1'b1;
    end
    if (req_fire & ~req_seg_load & legacy_on & req_sensitive) begin
      ev_set[`SPAT_EV_TRAP] = 1'b1;
    end
    if (req_fire & ~req_seg_load & ~prot_on & req_wide &
        (req_offset[15:0] == `SPAT_OFF_WRAP)) begin
      ev_set[`SPAT_EV_WRAP] = 1'b1;
    end
    if (mem_ack & ((state_ff == ST_DIR) | (state_ff == ST_TBL)) &
        ~mem_rdata[`SPAT_PRESENT_BIT]) begin
      ev_set[`SPAT_EV_PFAULT] = 1'b1;
    end
  end

  // Next holding state of the write channels
  always @* begin
    nxt_aw_have = aw_have_ff;
    nxt_w_have  = w_have_ff;
    if (wr_fire) begin
      nxt_aw_have = 1'b0;
      nxt_w_have  = 1'b0;
    end
    if (aw_fire) begin
      nxt_aw_have = 1'b1;
    end
    if (w_fire) begin
      nxt_w_have = 1'b1;
    end
  end

  // AXI write path: address and data taken in either order, response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff    <= 1'b0;
      w_have_ff     <= 1'b0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h00000000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SPAT_RESP_OKAY;
    end else begin
      aw_have_ff    <= nxt_aw_have;
      w_have_ff     <= nxt_w_have;
      // Ready drops while a word is held, so one write at most is pending
      s_axi_awready <= ~nxt_aw_have & ~aw_fire;
      s_axi_wready  <= ~nxt_w_have & ~w_fire;
      if (aw_fire) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `SPAT_RESP_OKAY : `SPAT_RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read path: one read at a time, unmapped offsets read zero with DECERR
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SPAT_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_fire;
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SPAT_RESP_OKAY;
        case (s_axi_araddr)
          `SPAT_OFF_CTRL:    s_axi_rdata <= {29'h0, ctrl_ff};
          `SPAT_OFF_STATUS:  s_axi_rdata <= {28'h0, status_ff};
          `SPAT_OFF_MASK:    s_axi_rdata <= {28'h0, mask_ff};
          `SPAT_OFF_FAULT:   s_axi_rdata <= fault_address_reg_ff;
          `SPAT_OFF_DIRBASE: s_axi_rdata <= directory_base_reg_ff;
          `SPAT_OFF_GTBASE:  s_axi_rdata <= gtbase_ff;
          `SPAT_OFF_LTBASE:  s_axi_rdata <= ltbase_ff;
          `SPAT_OFF_SEGBASE: s_axi_rdata <= segbase_ff;
          `SPAT_OFF_IMAGE:   s_axi_rdata <= {29'h0, image_ff};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SPAT_RESP_DECERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Software registers, sticky status and interrupt
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff               <= `SPAT_CTRL_RST;
      status_ff             <= `SPAT_EV_RST;
      mask_ff               <= `SPAT_EV_RST;
      fault_address_reg_ff  <= 32'h00000000;
      directory_base_reg_ff <= 32'h00000000;
      gtbase_ff             <= 32'h00000000;
      ltbase_ff             <= 32'h00000000;
      image_ff              <= `SPAT_CTRL_RST;
      irq                   <= 1'b0;
    end else begin
      // Event set wins over a same-cycle write-one-to-clear
      if (wr_fire & (awaddr_ff == `SPAT_OFF_STATUS) & wstrb_ff[0]) begin
        status_ff <= (status_ff & ~wdata_ff[`SPAT_EV_W-1:0]) | ev_set;
      end else begin
        status_ff <= status_ff | ev_set;
      end
      irq <= |((status_ff | ev_set) & mask_ff);
      if (wr_fire) begin
        case (awaddr_ff)
          `SPAT_OFF_CTRL:    ctrl_ff <= ctrl_wr[`SPAT_CTRL_W-1:0];
          `SPAT_OFF_MASK:    mask_ff <= mask_wr[`SPAT_EV_W-1:0];
          `SPAT_OFF_FAULT:   fault_address_reg_ff <= spat_merge(fault_address_reg_ff,
                                                                wdata_ff, wstrb_ff);
          `SPAT_OFF_DIRBASE: directory_base_reg_ff <= spat_merge(directory_base_reg_ff,
                                                                 wdata_ff, wstrb_ff);
          `SPAT_OFF_GTBASE:  gtbase_ff <= spat_merge(gtbase_ff, wdata_ff, wstrb_ff);
          `SPAT_OFF_LTBASE:  ltbase_ff <= spat_merge(ltbase_ff, wdata_ff, wstrb_ff);
          default: begin
          end
        endcase
      end
      // Any exception or interrupt saves the flags image and leaves legacy mode;
      // the legacy clear overrides that bit of a same-cycle software write of the control word
      if (|ev_set[`SPAT_EV_EXT:`SPAT_EV_TRAP] | ev_set[`SPAT_EV_PFAULT]) begin
        image_ff                   <= ctrl_ff;
        ctrl_ff[`SPAT_CTRL_LEGACY] <= 1'b0;
      end
      if (ev_set[`SPAT_EV_PFAULT]) begin
        fault_address_reg_ff <= lin_ff;
      end
    end
  end

  // Translation sequencer and table memory reads
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff   <= ST_IDLE;
      lin_ff     <= 32'h00000000;
      sel_ff     <= 16'h0000;
      dlo_ff     <= 32'h00000000;
      segbase_ff <= 32'h00000000;
      req_ready  <= 1'b0;
      rsp_valid  <= 1'b0;
      rsp_addr   <= 32'h00000000;
      rsp_fault  <= 1'b0;
      rsp_cause  <= `SPAT_CAUSE_NONE;
      mem_req    <= 1'b0;
      mem_addr   <= 32'h00000000;
    end else begin
      rsp_valid <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          req_ready <= 1'b1;
          if (req_fire) begin
            lin_ff <= nxt_lin;
            sel_ff <= req_selector;
            if (req_seg_load & prot_on & ~legacy_on) begin
              // Descriptor fetched by hardware from the chosen table
              req_ready <= 1'b0;
              mem_req   <= 1'b1;
              mem_addr  <= (req_selector[`SPAT_SEL_TABLE_BIT] ? ltbase_ff : gtbase_ff) +
                           {16'h0000, req_selector[15:3], 3'h0};
              state_ff  <= ST_DLO;
            end else if (req_seg_load) begin
              // Real and legacy bases come from the selector itself
              rsp_valid <= 1'b1;
              rsp_addr  <= {12'h000, req_selector, 4'h0};
              rsp_fault <= 1'b0;
              rsp_cause <= `SPAT_CAUSE_NONE;
            end else if (ev_set[`SPAT_EV_TRAP] | ev_set[`SPAT_EV_WRAP]) begin
              rsp_valid <= 1'b1;
              rsp_addr  <= 32'h00000000;
              rsp_fault <= 1'b1;
              rsp_cause <= ev_set[`SPAT_EV_TRAP] ? `SPAT_CAUSE_TRAP : `SPAT_CAUSE_WRAP;
            end else if (prot_on & page_on) begin
              req_ready <= 1'b0;
              mem_req   <= 1'b1;
              mem_addr  <= {directory_base_reg_ff[31:12], nxt_lin[31:22], 2'h0};
              state_ff  <= ST_DIR;
            end else begin
              rsp_valid <= 1'b1;
              rsp_addr  <= prot_on ? nxt_lin : (nxt_lin & `SPAT_REAL_MASK);
              rsp_fault <= 1'b0;
              rsp_cause <= `SPAT_CAUSE_NONE;
            end
          end
        end
        ST_DLO: begin
          if (mem_ack) begin
            dlo_ff   <= mem_rdata;
            mem_addr <= mem_addr + 32'h4;
            state_ff <= ST_DHI;
          end
        end
        ST_DHI: begin
          if (mem_ack) begin
            // Base split over both descriptor words
            segbase_ff <= {mem_rdata[31:24], mem_rdata[7:0], dlo_ff[31:16]};
            mem_req    <= 1'b0;
            rsp_valid  <= 1'b1;
            rsp_addr   <= {mem_rdata[31:24], mem_rdata[7:0], dlo_ff[31:16]};
            rsp_fault  <= 1'b0;
            rsp_cause  <= `SPAT_CAUSE_NONE;
            req_ready  <= 1'b1;
            state_ff   <= ST_IDLE;
          end
        end
        ST_DIR: begin
          if (mem_ack & ~mem_rdata[`SPAT_PRESENT_BIT]) begin
            mem_req   <= 1'b0;
            rsp_valid <= 1'b1;
            rsp_addr  <= 32'h00000000;
            rsp_fault <= 1'b1;
            rsp_cause <= `SPAT_CAUSE_PFAULT;
            req_ready <= 1'b1;
            state_ff  <= ST_IDLE;
          end else if (mem_ack) begin
            mem_addr <= {mem_rdata[31:12], lin_ff[21:12], 2'h0};
            state_ff <= ST_TBL;
          end
        end
        ST_TBL: begin
          if (mem_ack) begin
            mem_req   <= 1'b0;
            rsp_valid <= 1'b1;
            rsp_fault <= ~mem_rdata[`SPAT_PRESENT_BIT];
            rsp_cause <= mem_rdata[`SPAT_PRESENT_BIT] ? `SPAT_CAUSE_NONE :
                         `SPAT_CAUSE_PFAULT;
            rsp_addr  <= mem_rdata[`SPAT_PRESENT_BIT] ?
                         {mem_rdata[31:12], lin_ff[11:0]} : 32'h00000000;
            req_ready <= 1'b1;
            state_ff  <= ST_IDLE;
          end
        end
        default: begin
          mem_req   <= 1'b0;
          req_ready <= 1'b0;
          state_ff  <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // spat_translator

// file: rtl/spat_regs.vh
// Register offsets, field positions, reset values and codes of the address translator
`ifndef SPAT_REGS_VH
`define SPAT_REGS_VH
`define SPAT_OFF_CTRL      8'h00
`define SPAT_OFF_STATUS    8'h04
`define SPAT_OFF_MASK      8'h08
`define SPAT_OFF_FAULT     8'h0c
`define SPAT_OFF_DIRBASE   8'h10
`define SPAT_OFF_GTBASE    8'h14
`define SPAT_OFF_LTBASE    8'h18
`define SPAT_OFF_SEGBASE   8'h1c
`define SPAT_OFF_IMAGE     8'h20
`define SPAT_CTRL_PROT     0
`define SPAT_CTRL_PAGE     1
`define SPAT_CTRL_LEGACY   2
`define SPAT_CTRL_W        3
`define SPAT_CTRL_RST      3'h0
`define SPAT_EV_PFAULT     0
`define SPAT_EV_TRAP       1
`define SPAT_EV_WRAP       2
`define SPAT_EV_EXT        3
`define SPAT_EV_W          4
`define SPAT_EV_RST        4'h0
`define SPAT_CAUSE_NONE    2'h0
`define SPAT_CAUSE_PFAULT  2'h1
`define SPAT_CAUSE_TRAP    2'h2
`define SPAT_CAUSE_WRAP    2'h3
`define SPAT_PRESENT_BIT   0
`define SPAT_SEL_TABLE_BIT 2
`define SPAT_REAL_MASK     32'h000fffff
`define SPAT_OFF_WRAP      16'hffff
`define SPAT_RESP_OKAY     2'h0
`define SPAT_RESP_DECERR   2'h3
`endif

// file: testbench/spat_mem_model.sv
// Table memory model answering the translator's read port
`timescale 1ns/1ns
module spat_mem_model (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         mem_req,
  input  wire  [31:0] mem_addr,
  input  wire  [3:0]  delay,
  output logic        mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] words [bit [31:0]]; // Sparse tables, absent words read as zero
  logic [3:0]  wait_ff;            // Cycles already waited on this read
  // One-cycle acknowledge after the chosen delay; data scrambled when not valid
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_ack   <= 1'b0;
      wait_ff   <= 4'h0;
      mem_rdata <= 32'h0;
    end else if (mem_ack || !mem_req) begin
      mem_ack   <= 1'b0;
      wait_ff   <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_ff >= delay) begin
      mem_ack   <= 1'b1;
      mem_rdata <= words.exists(mem_addr) ? words[mem_addr] : 32'h0;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule // spat_mem_model

// file: testbench/spat_translator_assertions.sv
// Concurrent checks on the translator's ports
`timescale 1ns/1ns
module spat_translator_assertions (
  input wire        aclk,
  input wire        aresetn,
  input wire        req_valid,
  input wire        req_ready,
  input wire        req_seg_load,
  input wire        rsp_valid,
  input wire [31:0] rsp_addr,
  input wire        rsp_fault,
  input wire [1:0]  rsp_cause,
  input wire        mem_req,
  input wire [31:0] mem_addr,
  input wire        mem_ack,
  input wire [31:0] mem_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic        seg_ff;  // Walk belongs to a segment load
  logic        last_ff; // Next acknowledge ends the walk
  logic [31:0] low_ff;  // Last word read
  // Track which read of a walk runs; a new request restarts the count
  always @(posedge aclk) begin
    if (!aresetn) begin
      seg_ff  <= 1'b0;
      last_ff <= 1'b0;
      low_ff  <= 32'h0;
    end else if (req_valid && req_ready) begin
      seg_ff  <= req_seg_load;
      last_ff <= 1'b0;
    end else if (mem_ack) begin
      last_ff <= !last_ff;
      low_ff  <= mem_rdata;
    end
  end
  AST_WALK_REFUSE: assert property (
    mem_req |-> !req_ready)
    else $error("request accepted while a table walk runs");
  AST_MEM_HOLD: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("table read withdrawn before acknowledge");
  AST_DESC_HIGH: assert property (
    mem_ack && seg_ff && !last_ff |=> mem_req && mem_addr == $past(mem_addr) + 32'h4)
    else $error("descriptor high word read at wrong address");
  AST_DESC_BASE: assert property (
    mem_ack && seg_ff && last_ff |=> rsp_valid
      && rsp_addr == {$past(mem_rdata[31:24]), $past(mem_rdata[7:0]), $past(low_ff[31:16])})
    else $error("segment base not assembled from descriptor");
  AST_PTE_ADDR: assert property (
    mem_ack && !seg_ff && !last_ff && mem_rdata[0]
      |=> mem_req && mem_addr[31:12] == $past(mem_rdata[31:12]) && mem_addr[1:0] == 2'h0)
    else $error("table entry read outside the directed table");
  AST_FRAME: assert property (
    mem_ack && !seg_ff && last_ff && mem_rdata[0]
      |=> rsp_valid && !rsp_fault && rsp_addr[31:12] == $past(mem_rdata[31:12]))
    else $error("physical address not taken from frame");
  AST_PAGE_FAULT: assert property (
    mem_ack && !seg_ff && !mem_rdata[0] |=> rsp_valid && rsp_fault && rsp_cause == 2'h1)
    else $error("absent entry did not give a page fault");
  AST_FAULT_ZERO: assert property (
    rsp_valid && rsp_fault |-> rsp_addr == 32'h0 && rsp_cause != 2'h0)
    else $error("faulting answer carries an address");
  COV_SEG_WALK: cover property (mem_ack && seg_ff && last_ff);
  COV_PAGE_WALK: cover property (mem_ack && !seg_ff && last_ff && mem_rdata[0]);
  COV_PAGE_FAULT: cover property (rsp_valid && rsp_cause == 2'h1);
endmodule // spat_translator_assertions

bind spat_translator spat_translator_assertions i_spat_translator_assertions (
  .aclk, .aresetn, .req_valid, .req_ready, .req_seg_load, .rsp_valid, .rsp_addr,
  .rsp_fault, .rsp_cause, .mem_req, .mem_addr, .mem_ack, .mem_rdata);

// file: testbench/spat_translator_tb.sv
// Self-checking bench for the segment and page address translator
`timescale 1ns/1ns
`include "spat_regs.vh"
module spat_translator_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, req_valid, req_ready, req_seg_load, req_off32, req_wide;
  logic        req_sensitive, req_event, rsp_valid, rsp_fault, mem_req, mem_ack, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;                    // Register byte addresses
  logic [31:0] s_axi_wdata, s_axi_rdata, req_offset, rsp_addr, mem_addr, mem_rdata;
  logic [3:0]  s_axi_wstrb, delay;                            // Strobes, memory delay
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp_cause;
  logic [15:0] req_selector;
  int          fails, samples_checked;
  spat_translator i_spat_translator (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req_ready, .req_seg_load,
    .req_selector, .req_offset, .req_off32, .req_wide, .req_sensitive, .req_event, .rsp_valid,
    .rsp_addr, .rsp_fault, .rsp_cause, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .irq);
  spat_mem_model i_spat_mem_model (.aclk, .aresetn, .mem_req, .mem_addr, .delay, .mem_ack,
    .mem_rdata);
  always #5 aclk = ~aclk;
  // Compare and count; an unknown never matches
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", {30'h0, r}, {30'h0, `SPAT_RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk("rdata", d, exp);
  endtask
  // One translation; f is {off32, wide, sensitive, event}, c is {fault, cause}
  task automatic xl(input logic s, input logic [15:0] sel, input logic [31:0] off,
                    input logic [3:0] f, output logic [31:0] a, output logic [31:0] c);
    @(posedge aclk);
    req_valid    <= 1'b1;
    req_seg_load <= s;
    req_selector <= sel;
    req_offset   <= off;
    {req_off32, req_wide, req_sensitive, req_event} <= f;
    do @(posedge aclk); while (!req_ready);
    req_valid <= 1'b0;
    req_event <= 1'b0;
    do @(posedge aclk); while (!rsp_valid);
    a = rsp_addr;
    c = {29'h0, rsp_fault, rsp_cause};
  endtask
  // Reset values, read-back, unmapped and read-only places
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(`SPAT_OFF_CTRL, 32'h0);
    rd(`SPAT_OFF_STATUS, 32'h0);
    wr(`SPAT_OFF_FAULT, 32'h1234_5678);
    rd(`SPAT_OFF_FAULT, 32'h1234_5678);
    axi_rd(8'h24, d, r);
    chk("unmapped", d, 32'h0);
    chk("unmapped_resp", {30'h0, r}, {30'h0, `SPAT_RESP_DECERR});
    axi_wr(`SPAT_OFF_SEGBASE, 32'hffff_ffff, r);
    chk("ro_write", {30'h0, r}, {30'h0, `SPAT_RESP_DECERR});
    rd(`SPAT_OFF_SEGBASE, 32'h0);
    $display("test regs done");
  endtask
  // Real mode, with the paging bit set alone, so no table is read
  task automatic t_real;
    logic [31:0] a, c;
    wr(`SPAT_OFF_CTRL, 32'h2);
    xl(1'b0, 16'h1234, 32'h0001_0010, 4'h0, a, c);
    chk("real", a, 32'h0001_2350);
    xl(1'b0, 16'hffff, 32'h0000_0010, 4'h0, a, c);
    chk("real_top", a, 32'h0);
    xl(1'b1, 16'h0800, 32'h0, 4'h0, a, c);
    chk("real_base", a, 32'h0000_8000);
    xl(1'b0, 16'h0100, 32'h0000_ffff, 4'h4, a, c);
    chk("wrap", c, {30'h1, `SPAT_CAUSE_WRAP});
    rd(`SPAT_OFF_STATUS, 32'h4);
    wr(`SPAT_OFF_STATUS, 32'h4);
    rd(`SPAT_OFF_STATUS, 32'h0);
    $display("test real done");
  endtask
  // Descriptor loads from both tables with a slow memory, then offsets
  task automatic t_prot;
    logic [31:0] a, c;
    wr(`SPAT_OFF_CTRL, 32'h1);
    wr(`SPAT_OFF_GTBASE, 32'h0000_1000);
    wr(`SPAT_OFF_LTBASE, 32'h0000_2000);
    i_spat_mem_model.words[32'h1010] = 32'h5678_0001;
    i_spat_mem_model.words[32'h1014] = 32'h9a00_0034;
    i_spat_mem_model.words[32'h2010] = 32'h0100_0001;
    i_spat_mem_model.words[32'h2014] = 32'h0;
    delay <= 4'h2;
    xl(1'b1, 16'h0014, 32'h0, 4'h0, a, c);
    chk("local", a, 32'h0000_0100);
    xl(1'b1, 16'h0010, 32'h0, 4'h0, a, c);
    chk("global", a, 32'h9a34_5678);
    xl(1'b0, 16'h0010, 32'h0001_0004, 4'h8, a, c);
    chk("lin32", a, 32'h9a35_567c);
    xl(1'b0, 16'h0010, 32'h0001_0004, 4'h0, a, c);
    chk("lin16", a, 32'h9a34_567c);
    $display("test protected done");
  endtask
  // Two-level walk, an absent entry, and the interrupt path
  task automatic t_page;
    logic [31:0] a, c, lin;
    lin = 32'h9a34_5678;
    i_spat_mem_model.words[{20'h00030, lin[31:22], 2'h0}] = 32'h0004_0001;
    i_spat_mem_model.words[{20'h00040, lin[21:12], 2'h0}] = 32'h1234_5001;
    wr(`SPAT_OFF_CTRL, 32'h3);
    wr(`SPAT_OFF_DIRBASE, 32'h0003_0000);
    wr(`SPAT_OFF_MASK, 32'h1);
    xl(1'b0, 16'h0010, 32'h0, 4'h8, a, c);
    chk("paged", a, {20'h12345, lin[11:0]});
    xl(1'b0, 16'h0010, 32'h0000_1000, 4'h8, a, c);
    chk("pfault", c, {30'h1, `SPAT_CAUSE_PFAULT});
    rd(`SPAT_OFF_FAULT, lin + 32'h1000);
    // Absent directory entry faults at the first level
    xl(1'b0, 16'h0010, 32'h0040_0000, 4'h8, a, c);
    chk("pde_fault", c, {30'h1, `SPAT_CAUSE_PFAULT});
    rd(`SPAT_OFF_FAULT, lin + 32'h0040_0000);
    // Legacy task relocated by paging
    i_spat_mem_model.words[32'h0003_0000] = 32'h0004_0001;
    i_spat_mem_model.words[32'h0004_0000] = 32'h0777_7001;
    wr(`SPAT_OFF_CTRL, 32'h7);
    xl(1'b0, 16'h0000, 32'h0000_0678, 4'h0, a, c);
    chk("legacy_paged", a, 32'h0777_7678);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wr(`SPAT_OFF_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq_mask", {31'h0, irq}, 32'h0);
    wr(`SPAT_OFF_MASK, 32'h1);
    wr(`SPAT_OFF_STATUS, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    $display("test paging done");
  endtask
  // Legacy task addressing, trap on sensitive work, leaving on exceptions
  task automatic t_legacy;
    logic [31:0] a, c;
    wr(`SPAT_OFF_CTRL, 32'h5);
    xl(1'b0, 16'hffff, 32'h0000_0020, 4'h0, a, c);
    chk("legacy", a | c, 32'h0000_0010);
    xl(1'b0, 16'h0, 32'h0, 4'h2, a, c);
    chk("trap", c, {30'h1, `SPAT_CAUSE_TRAP});
    rd(`SPAT_OFF_CTRL, 32'h1);
    rd(`SPAT_OFF_IMAGE, 32'h5);
    xl(1'b0, 16'h0, 32'h0, 4'h2, a, c);
    chk("native", c, 32'h0);
    wr(`SPAT_OFF_CTRL, 32'h5);
    wr(`SPAT_OFF_STATUS, 32'h2);
    xl(1'b0, 16'h0, 32'h0, 4'h1, a, c);
    rd(`SPAT_OFF_CTRL, 32'h1);
    rd(`SPAT_OFF_STATUS, 32'h8);
    $display("test legacy done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    final_report();
  end
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h0;
    {s_axi_rready, req_valid, req_seg_load, req_off32, req_wide, req_sensitive} = 6'h0;
    {req_event, s_axi_awaddr, s_axi_araddr, req_selector, delay} = 37'h0;
    {s_axi_wdata, req_offset, s_axi_wstrb} = {64'h0, 4'hf};
    {fails, samples_checked} = 64'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_real();
    t_prot();
    t_page();
    t_legacy();
    final_report();
  end
endmodule // spat_translator_tb
